// ===== core/aowc_pkg.sv
// Constants, register map and carrier types for the analog output waveform
// controller. Assumes a single 10 MHz clock and an AXI4-Lite host.
package aowc_pkg;
   localparam int          CLK_HZ       = 10_000_000;
   localparam int          US_NS        = 1_000;
   localparam int          CYC_PER_US   = CLK_HZ / 1_000_000;
   localparam int          US_PER_MS    = 1_000;
   localparam int          MS_PER_S     = 1_000;
   localparam logic [15:0] ZERO_CODE    = 16'h0000;
   // Byte offsets
   localparam logic [7:0]  A_CTRL       = 8'h00;
   localparam logic [7:0]  A_DVAL       = 8'h04;
   localparam logic [7:0]  A_DSEL       = 8'h08;
   localparam logic [7:0]  A_SWTRIG     = 8'h0C;
   localparam logic [7:0]  A_WDCFG      = 8'h10;
   localparam logic [7:0]  A_WDSVC      = 8'h14;
   localparam logic [7:0]  A_STAT       = 8'h18;
   localparam logic [7:0]  A_MASK       = 8'h1C;
   localparam logic [7:0]  A_TSTAMP     = 8'h20;
   localparam logic [7:0]  A_GENCFG     = 8'h40;
   localparam logic [7:0]  A_GENRATE    = 8'h60;
   localparam logic [7:0]  A_TABLE      = 8'h80;
   localparam logic [7:0]  A_OUT        = 8'hC0;
   localparam logic [7:0]  A_TCAP       = 8'hE0;
   // Control register fields
   localparam int          CTRL_TSEL_LO = 0;
   localparam int          CTRL_CURR_LO = 8;
   // Generator config fields
   localparam int          G_EN         = 0;
   localparam int          G_CONT       = 1;
   localparam int          G_TRIG       = 2;
   localparam int          G_SYNC       = 3;
   localparam int          G_LAST_LO    = 8;
   // Status bit positions
   localparam int          ST_WDOG      = 0;
   localparam int          ST_TEMP      = 1;
   localparam int          ST_DIAG_LO   = 8;
   localparam int          ST_DONE_LO   = 16;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;

   typedef enum logic [1:0] {
      AOWC_TB_US = 2'b00,
      AOWC_TB_MS = 2'b01,
      AOWC_TB_S  = 2'b10
   } aowc_tbase_t;

   typedef enum logic [1:0] {
      AOWC_TR_SW   = 2'b00,
      AOWC_TR_HW   = 2'b01,
      AOWC_TR_SYNC = 2'b10
   } aowc_tsel_t;

   typedef struct packed {
      logic [15:0] value;
      logic [15:0] repeats;
   } aowc_entry_t;
endpackage

// ===== core/aowc_top.sv
// Analog output waveform controller: direct outputs, per channel
// generators, watchdog, diagnostics and time stamps behind AXI4-Lite.
// Assumes the trigger and diagnostic pins are asynchronous to clk_in.
`timescale 1ns/1ps
module aowc_top
   import aowc_pkg::*;
#(
   parameter int NCH   = 8,
   parameter int DEPTH = 16
) (
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   input  wire logic [7:0]        s_awaddr_in,
   input  wire logic              s_awvalid_in,
   output logic                   s_awready_out,
   input  wire logic [31:0]       s_wdata_in,
   input  wire logic [3:0]        s_wstrb_in,
   input  wire logic              s_wvalid_in,
   output logic                   s_wready_out,
   output logic [1:0]             s_bresp_out,
   output logic                   s_bvalid_out,
   input  wire logic              s_bready_in,
   input  wire logic [7:0]        s_araddr_in,
   input  wire logic              s_arvalid_in,
   output logic                   s_arready_out,
   output logic [31:0]            s_rdata_out,
   output logic [1:0]             s_rresp_out,
   output logic                   s_rvalid_out,
   input  wire logic              s_rready_in,
   input  wire logic              hw_trig_in,
   input  wire logic              sync_trig_in,
   input  wire logic [NCH-1:0]    fault_in,
   input  wire logic              overtemp_in,
   output logic [NCH*16-1:0]      dac_code_out,
   output logic [NCH-1:0]         current_mode_out,
   output logic                   irq_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int STB = ST_DONE_LO + NCH;
   initial begin
      if (NCH != 8 || DEPTH < 2 || DEPTH > 16) begin
         $error("aowc_top: NCH must be 8 and DEPTH 2..16");
      end
   end

   // Two-stage synchronisers; stage one is read only by stage two
   logic [NCH+2:0] s1_r, s2_r, s3_r;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= {overtemp_in, fault_in, sync_trig_in, hw_trig_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic hw_edge, sync_edge;
   assign hw_edge   = s2_r[0] & ~s3_r[0];
   assign sync_edge = s2_r[1] & ~s3_r[1];

   // Registers
   logic [31:0]      ctrl_r, dval_r, wdcfg_r, mask_r, stat_r;
   logic [NCH-1:0]   dsel_r, pend_r;
   logic [31:0]      gcfg_r [NCH];
   logic [31:0]      grate_r [NCH];
   aowc_entry_t      tbl_r [NCH][DEPTH];
   logic [15:0]      out_r [NCH];
   logic [31:0]      tcap_r [NCH];
   logic [31:0]      tstamp_r;
   logic             wd_fire, wd_svc, sw_trig;
   logic [NCH-1:0]   gen_done, gen_upd;
   logic [NCH-1:0]   gen_step;

   // AXI4-Lite write: address and data may arrive in either order
   logic        aw_h_r, w_h_r;
   logic [7:0]  awa_r;
   logic [31:0] wd_r;
   logic [3:0]  ws_r;
   logic        wr_go;
   assign s_awready_out = ~aw_h_r & ~s_bvalid_out;
   assign s_wready_out  = ~w_h_r & ~s_bvalid_out;
   assign wr_go = aw_h_r & w_h_r & ~s_bvalid_out;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         aw_h_r       <= 1'b0;
         w_h_r        <= 1'b0;
         awa_r        <= '0;
         wd_r         <= '0;
         ws_r         <= '0;
         s_bvalid_out <= 1'b0;
         s_bresp_out  <= RESP_OKAY;
      end else begin
         if (s_awvalid_in && s_awready_out) begin
            aw_h_r <= 1'b1;
            awa_r  <= s_awaddr_in;
         end
         if (s_wvalid_in && s_wready_out) begin
            w_h_r <= 1'b1;
            wd_r  <= s_wdata_in;
            ws_r  <= s_wstrb_in;
         end
         if (wr_go) begin
            aw_h_r       <= 1'b0;
            w_h_r        <= 1'b0;
            s_bvalid_out <= 1'b1;
            s_bresp_out  <= (awa_r < A_TABLE || awa_r >= A_OUT) &&
                            (awa_r > A_TSTAMP) && (awa_r < A_GENCFG)
                            ? RESP_SLVERR : RESP_OKAY;
         end else if (s_bvalid_out && s_bready_in) begin
            s_bvalid_out <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  b);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (b[i]) r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction

   logic [7:0] wa;
   assign wa = awa_r;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ctrl_r  <= '0;
         dval_r  <= '0;
         dsel_r  <= '0;
         wdcfg_r <= '0;
         mask_r  <= '0;
      end else if (wr_go) begin
         case (wa)
            A_CTRL:  ctrl_r  <= merge(ctrl_r, wd_r, ws_r);
            A_DVAL:  dval_r  <= merge(dval_r, wd_r, ws_r);
            A_DSEL:  dsel_r  <= wd_r[NCH-1:0];
            A_WDCFG: wdcfg_r <= merge(wdcfg_r, wd_r, ws_r);
            A_MASK:  mask_r  <= merge(mask_r, wd_r, ws_r);
            default: ;
         endcase
      end
   end
   assign sw_trig = wr_go && wa == A_SWTRIG && wd_r[0];
   assign wd_svc  = wr_go && wa == A_WDSVC;
   assign current_mode_out = ctrl_r[CTRL_CURR_LO +: NCH];

   // Direct access: a write arms the selected channels until the trigger
   logic direct_trig;
   always_comb begin
      case (aowc_tsel_t'(ctrl_r[CTRL_TSEL_LO +: 2]))
         AOWC_TR_SW:   direct_trig = sw_trig;
         AOWC_TR_HW:   direct_trig = hw_edge;
         AOWC_TR_SYNC: direct_trig = sync_edge;
         default:      direct_trig = 1'b0;
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pend_r <= '0;
      end else if (wr_go && wa == A_DSEL) begin
         pend_r <= wd_r[NCH-1:0];
      end else if (direct_trig) begin
         pend_r <= '0;
      end
   end

   // Free running time stamp
   always_ff @(posedge clk_in) begin
      if (reset_in) tstamp_r <= '0;
      else          tstamp_r <= tstamp_r + 32'h0000_0001;
   end

   // Per-channel generators
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         logic [AW-1:0] idx_r;
         logic [15:0]   rep_r;
         logic [31:0]   div_r;
         logic          run_r;
         logic          fin_r;
         logic          tick, trg;
         logic [31:0]   cfg;
         logic [AW-1:0] last;
         assign cfg  = gcfg_r[g];
         assign last = cfg[G_LAST_LO +: AW];
         assign trg  = cfg[G_SYNC] ? sync_edge : hw_edge;
         assign tick = run_r && (cfg[G_TRIG] ? trg
                                             : div_r >= grate_r[g]);
         assign gen_step[g] = tick;
         always_ff @(posedge clk_in) begin
            if (reset_in) begin
               gcfg_r[g]  <= '0;
               grate_r[g] <= '0;
            end else if (wr_go && wa == A_GENCFG + 8'(g*4)) begin
               gcfg_r[g]  <= merge(gcfg_r[g], wd_r, ws_r);
            end else if (wr_go && wa == A_GENRATE + 8'(g*4)) begin
               grate_r[g] <= merge(grate_r[g], wd_r, ws_r);
            end else if (gen_done[g]) begin
               gcfg_r[g][G_EN] <= 1'b0;
            end
         end
         always_ff @(posedge clk_in) begin
            if (wr_go && wa[7:6] == A_TABLE[7:6] && wa[5:3] == 3'(g)
                && 32'(wa[2]) < 32'(DEPTH)) begin
               tbl_r[g][AW'(wa[2])] <= wd_r;
            end
         end
         always_ff @(posedge clk_in) begin
            if (reset_in) begin
               idx_r <= '0;
               rep_r <= '0;
               div_r <= '0;
               run_r <= 1'b0;
               fin_r <= 1'b0;
            end else if (!cfg[G_EN] || wd_fire) begin
               idx_r <= '0;
               rep_r <= '0;
               div_r <= '0;
               run_r <= 1'b0;
               fin_r <= 1'b0;
            end else begin
               run_r <= 1'b1;
               div_r <= tick || cfg[G_TRIG] ? '0 : div_r + 32'h1;
               if (tick) begin
                  if (rep_r + 16'h1 < tbl_r[g][idx_r].repeats) begin
                     rep_r <= rep_r + 16'h1;
                  end else begin
                     rep_r <= '0;
                     idx_r <= idx_r == last ? '0 : idx_r + AW'(1);
                     // Last entry has had its full hold; stop on next step
                     if (idx_r == last && !cfg[G_CONT]) fin_r <= 1'b1;
                  end
               end
            end
         end
         assign gen_done[g] = tick && fin_r;
         assign gen_upd[g] = tick || (pend_r[g] && direct_trig);
         always_ff @(posedge clk_in) begin
            if (reset_in) begin
               out_r[g]  <= ZERO_CODE;
               tcap_r[g] <= '0;
            end else if (wd_fire) begin
               out_r[g]  <= ZERO_CODE;
            end else if (gen_done[g]) begin
               out_r[g]  <= ZERO_CODE;
               tcap_r[g] <= tstamp_r;
            end else if (gen_upd[g]) begin
               out_r[g]  <= tick ? tbl_r[g][idx_r].value
                                 : dval_r[15:0];
               tcap_r[g] <= tstamp_r;
            end
         end
         assign dac_code_out[g*16 +: 16] = out_r[g];
      end
   endgenerate

   // Watchdog: cfg[15:0] period, [17:16] base, [31] enable
   logic [31:0] wd_pre_r;
   logic [15:0] wd_cnt_r;
   logic [31:0] wd_unit;
   logic        wd_en;
   assign wd_en = wdcfg_r[31];
   always_comb begin
      case (aowc_tbase_t'(wdcfg_r[17:16]))
         AOWC_TB_MS: wd_unit = 32'(CYC_PER_US * US_PER_MS);
         AOWC_TB_S:  wd_unit = 32'(CYC_PER_US * US_PER_MS * MS_PER_S);
         default:    wd_unit = 32'(CYC_PER_US);
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (reset_in || !wd_en || wd_svc) begin
         wd_pre_r <= '0;
         wd_cnt_r <= '0;
      end else if (wd_cnt_r != wdcfg_r[15:0]) begin
         if (wd_pre_r + 32'h1 >= wd_unit) begin
            wd_pre_r <= '0;
            wd_cnt_r <= wd_cnt_r + 16'h1;
         end else begin
            wd_pre_r <= wd_pre_r + 32'h1;
         end
      end
   end
   assign wd_fire = wd_en && wd_cnt_r == wdcfg_r[15:0]
                    && wdcfg_r[15:0] != 16'h0000;

   // Sticky status: set wins over write-one-to-clear
   logic [31:0] ev, w1c;
   always_comb begin
      ev = '0;
      ev[ST_WDOG] = wd_fire;
      ev[ST_TEMP] = s2_r[NCH+2];
      ev[ST_DIAG_LO +: NCH] = s2_r[NCH+1:2];
      ev[ST_DONE_LO +: NCH] = gen_done;
      w1c = (wr_go && wa == A_STAT) ? wd_r : '0;
   end
   always_ff @(posedge clk_in) begin
      if (reset_in) stat_r <= '0;
      else          stat_r <= (stat_r & ~w1c) | ev;
   end
   always_ff @(posedge clk_in) begin
      if (reset_in) irq_out <= 1'b0;
      else          irq_out <= |(stat_r & mask_r);
   end

   // AXI4-Lite read
   logic [31:0] rd;
   logic        rd_ok;
   always_comb begin
      rd    = '0;
      rd_ok = 1'b1;
      case (s_araddr_in)
         A_CTRL:   rd = ctrl_r;
         A_DVAL:   rd = dval_r;
         A_DSEL:   rd = {24'h0, dsel_r};
         A_SWTRIG: rd = {24'h0, pend_r};
         A_WDCFG:  rd = wdcfg_r;
         A_WDSVC:  rd = {16'h0, wd_cnt_r};
         A_STAT:   rd = stat_r;
         A_MASK:   rd = mask_r;
         A_TSTAMP: rd = tstamp_r;
         default: begin
            if (s_araddr_in[7:5] == A_GENCFG[7:5])
               rd = gcfg_r[s_araddr_in[4:2]];
            else if (s_araddr_in[7:5] == A_GENRATE[7:5])
               rd = grate_r[s_araddr_in[4:2]];
            else if (s_araddr_in[7:5] == A_OUT[7:5])
               rd = {16'h0, out_r[s_araddr_in[4:2]]};
            else if (s_araddr_in[7:5] == A_TCAP[7:5])
               rd = tcap_r[s_araddr_in[4:2]];
            else
               rd_ok = 1'b0;
         end
      endcase
   end
   assign s_arready_out = ~s_rvalid_out;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_rvalid_out <= 1'b0;
         s_rdata_out  <= '0;
         s_rresp_out  <= RESP_OKAY;
      end else if (s_arvalid_in && s_arready_out) begin
         s_rvalid_out <= 1'b1;
         s_rdata_out  <= rd;
         s_rresp_out  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready_in) begin
         s_rvalid_out <= 1'b0;
      end
   end

   // Checks
   property p_reset_zero;
      @(posedge clk_in) reset_in |=> dac_code_out == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("outputs not zero after reset");
   property p_wd_zero;
      @(posedge clk_in) disable iff (reset_in)
         wd_fire |=> dac_code_out == '0;
   endproperty
   a_wd_zero: assert property (p_wd_zero)
      else $error("watchdog expiry left outputs nonzero");
   property p_wd_svc;
      @(posedge clk_in) disable iff (reset_in)
         wd_svc |=> wd_cnt_r == 16'h0000;
   endproperty
   a_wd_svc: assert property (p_wd_svc)
      else $error("watchdog not restarted by service");
   property p_wd_off;
      @(posedge clk_in) disable iff (reset_in)
         !wd_en |=> wd_cnt_r == 16'h0000 && !wd_fire;
   endproperty
   a_wd_off: assert property (p_wd_off)
      else $error("watchdog counted while disabled");
   property p_edge_once;
      @(posedge clk_in) disable iff (reset_in)
         hw_edge |=> !hw_edge;
   endproperty
   a_edge_once: assert property (p_edge_once)
      else $error("trigger edge seen twice");
   property p_direct_hold;
      @(posedge clk_in) disable iff (reset_in)
         !gen_upd[0] && !wd_fire && !gen_done[0] |=> $stable(out_r[0]);
   endproperty
   a_direct_hold: assert property (p_direct_hold)
      else $error("output changed without trigger");
   property p_single_stop;
      @(posedge clk_in) disable iff (reset_in)
         gen_done[0] |=> out_r[0] == ZERO_CODE ##1 !gcfg_r[0][G_EN];
   endproperty
   a_single_stop: assert property (p_single_stop)
      else $error("single mode did not stop at zero");
   property p_tcap;
      @(posedge clk_in) disable iff (reset_in)
         gen_upd[0] && !wd_fire |=> tcap_r[0] == $past(tstamp_r);
   endproperty
   a_tcap: assert property (p_tcap)
      else $error("time stamp not captured on update");
   property p_diag;
      @(posedge clk_in) disable iff (reset_in)
         s2_r[2] |=> stat_r[ST_DIAG_LO];
   endproperty
   a_diag: assert property (p_diag)
      else $error("fault not latched");
endmodule

// ===== tb/aowc_field.sv
// Model of the far side: trigger sources and the eight output stages.
// Assumes the bench calls pulse() and sets the fault requests.
`timescale 1ns/1ps
module aowc_field (
   input  wire logic [7:0] current_mode_in,
   input  wire logic [7:0] short_req_in,
   input  wire logic [7:0] break_req_in,
   output logic            hw_trig_out,
   output logic            sync_trig_out,
   output logic [7:0]      fault_out
);
   // A short only shows on a voltage stage, a break only on a current one
   assign fault_out = (short_req_in & ~current_mode_in) |
                      (break_req_in & current_mode_in);

   initial begin
      hw_trig_out = 1'b0;
      sync_trig_out = 1'b0;
   end

   // Odd offsets: these pins know nothing of the core clock
   task automatic pulse(input bit sync_src);
      #37;
      if (sync_src) begin
         sync_trig_out = 1'b1;
      end else begin
         hw_trig_out = 1'b1;
      end
      #350;
      hw_trig_out = 1'b0;
      sync_trig_out = 1'b0;
   endtask
endmodule

// ===== tb/analog_output_waveform_controller_bench.sv
// Self-checking bench for the output controller, host on AXI4-Lite.
// Assumes aowc_pkg, aowc_top and the aowc_field model are compiled.
`timescale 1ns/1ps
module analog_output_waveform_controller_bench;
   import aowc_pkg::*;
   logic         clk_in, reset_in, awvalid, wvalid, bready, arvalid;
   logic         rready, awready, wready, bvalid, arready, rvalid;
   logic         hw, sy, overtemp, irq;
   logic [7:0]   awaddr, araddr, fault, cmode, shrt, brk, cm, msk;
   logic [31:0]  wdata, rdata, d, t0, t1, tc;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp, resp;
   logic [127:0] dac, old, exp;
   logic [15:0]  v, va, vb, x1, x2, x3;
   logic [2:0]   c;
   int           miscompares, n_tests, cyc, m, k, ta, tb1, tb2, tb3;

   aowc_top aowc_top_i (.clk_in(clk_in), .reset_in(reset_in),
      .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready),
      .s_wdata_in(wdata), .s_wstrb_in(wstrb), .s_wvalid_in(wvalid),
      .s_wready_out(wready), .s_bresp_out(bresp), .s_bvalid_out(bvalid),
      .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
      .s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp),
      .s_rvalid_out(rvalid), .s_rready_in(rready), .hw_trig_in(hw),
      .sync_trig_in(sy), .fault_in(fault), .overtemp_in(overtemp),
      .dac_code_out(dac), .current_mode_out(cmode), .irq_out(irq));
   aowc_field aowc_field_i (.current_mode_in(cmode), .short_req_in(shrt),
      .break_req_in(brk), .hw_trig_out(hw), .sync_trig_out(sy),
      .fault_out(fault));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) cyc <= cyc + 1;

   function automatic logic [15:0] ch(input logic [127:0] q, input int n);
      return q[16*n +: 16];
   endfunction
   function automatic logic [127:0] apply(input logic [127:0] o,
      input logic [15:0] val, input logic [7:0] sel);
      for (int i = 0; i < 8; i++) begin
         if (sel[i]) o[16*i +: 16] = val;
      end
      return o;
   endfunction

   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      bit ad, dd;
      ad = 0;
      dd = 0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge clk_in);
         if (!ad && awready === 1'b1) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!dd && wready === 1'b1) begin
            dd = 1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk_in);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dat);
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge clk_in);
      while (arready !== 1'b1) @(posedge clk_in);
      arvalid <= 1'b0;
      @(posedge clk_in);
      while (rvalid !== 1'b1) @(posedge clk_in);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // Sampled on the falling edge so register updates have landed
   task automatic nxt(output logic [15:0] val, output int t);
      logic [15:0] p;
      int n;
      p = ch(dac, c);
      n = 0;
      while (ch(dac, c) === p && n < 300) begin
         @(negedge clk_in);
         n++;
      end
      val = ch(dac, c);
      t = cyc;
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      $display("FAIL watchdog expected finish seen hang");
      conclude();
   end

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, overtemp} = '0;
      {awaddr, araddr, wdata, shrt, brk, cyc, old} = '0;
      wstrb = 4'hF;
      reset_in = 1'b1;
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      void'($urandom(76));
      @(negedge clk_in);
      chk("dac_reset", {31'h0, dac === 128'h0}, 32'h1);
      chk("mode_reset", {24'h0, cmode}, 32'h0);
      chk("irq_reset", {31'h0, irq}, 32'h0);
      $display("test reset done");
      for (m = 0; m < 3; m++) begin
         cm = $urandom;
         v = $urandom;
         msk = $urandom | 1;
         wr(A_CTRL, {16'h0, cm, 6'h0, m[1:0]});
         wr(A_DVAL, {16'h0, v});
         wr(A_DSEL, {24'h0, msk});
         repeat (5) @(posedge clk_in);
         chk("mode", {24'h0, cmode}, {24'h0, cm});
         chk("held", {31'h0, dac === old}, 32'h1);
         rd(A_TSTAMP, t0);
         case (m)
            0: wr(A_SWTRIG, 32'h1);
            1: aowc_field_i.pulse(1'b0);
            default: aowc_field_i.pulse(1'b1);
         endcase
         repeat (6) @(posedge clk_in);
         exp = apply(old, v, msk);
         chk("applied", {31'h0, dac === exp}, 32'h1);
         rd(A_TCAP, tc);
         rd(A_TSTAMP, t1);
         chk("stamp", {31'h0, tc > t0 && tc < t1}, 32'h1);
         old = exp;
      end
      $display("test direct done");
      for (k = 0; k < 2; k++) begin
         c = $urandom_range(7);
         va = ($urandom & 16'h7FFF) | 16'h1;
         vb = ~va;
         wr(A_GENRATE + {3'b0, c, 2'b0}, 32'h8);
         wr(A_TABLE + {2'b0, c, 3'b0}, {va, 16'h2});
         wr(A_TABLE + {2'b0, c, 3'b100}, {vb, 16'h1});
         wr(A_GENCFG + {3'b0, c, 2'b0}, 32'h101 | (k << 1));
         if (ch(dac, c) !== va) nxt(x1, ta);
         nxt(x1, tb1);
         nxt(x2, tb2);
         nxt(x3, tb3);
         chk("second", {16'h0, x1}, {16'h0, vb});
         if (k == 0) begin
            chk("stop", {16'h0, x2}, 32'h0);
            exp = old;
            exp[16*c +: 16] = 16'h0;
            chk("others", {31'h0, dac === exp}, 32'h1);
            rd(A_STAT, d);
            chk("done", {31'h0, d[ST_DONE_LO + c]}, 32'h1);
            old = exp;
         end else begin
            chk("wrap", {x2, x3}, {va, vb});
            chk("hold", tb3 - tb2, 2 * (tb2 - tb1));
            wr(A_GENCFG + {3'b0, c, 2'b0}, 32'h0);
            old[16*c +: 16] = ch(dac, c);
         end
      end
      $display("test generator done");
      wr(A_STAT, 32'hFFFFFFFF);
      wr(A_MASK, 32'h0);
      shrt <= 8'hFF;
      overtemp <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(A_STAT, d);
      chk("events", {16'h0, d[15:0]}, {16'h0, ~cm, 8'h02});
      chk("masked", {31'h0, irq}, 32'h0);
      wr(A_MASK, 32'h2);
      repeat (3) @(posedge clk_in);
      chk("irq", {31'h0, irq}, 32'h1);
      shrt <= 8'h0;
      overtemp <= 1'b0;
      repeat (6) @(posedge clk_in);
      wr(A_STAT, 32'hFFFF);
      repeat (3) @(posedge clk_in);
      chk("irq_clr", {31'h0, irq}, 32'h0);
      rd(A_STAT, d);
      chk("cleared", {16'h0, d[15:0]}, 32'h0);
      rd(8'h24, d);
      chk("bad_rd", {resp, d[29:0]}, {RESP_SLVERR, 30'h0});
      wr(8'h24, 32'h1);
      chk("bad_wr", {30'h0, resp}, {30'h0, RESP_SLVERR});
      $display("test events done");
      wr(A_WDCFG, 32'h80000005);
      repeat (4) begin
         repeat (25) @(posedge clk_in);
         wr(A_WDSVC, 32'h1);
      end
      repeat (40) @(posedge clk_in);
      chk("alive", {31'h0, dac === old}, 32'h1);
      repeat (30) @(posedge clk_in);
      chk("forced", {31'h0, dac === 128'h0}, 32'h1);
      rd(A_STAT, d);
      chk("expired", {31'h0, d[ST_WDOG]}, 32'h1);
      $display("test watchdog done");
      conclude();
   end
endmodule
